// ==== core/adc_readout_cfg.svh ====
// offsets, field positions and reset values of the converter register block
`ifndef ADC_READOUT_CFG_SVH
`define ADC_READOUT_CFG_SVH
`define OFS_CONTROL_ZERO   8'h00
`define OFS_CONTROL_ONE    8'h04
`define OFS_RESULT_UPPER   8'h08
`define OFS_RESULT_LOWER   8'h0c
`define OFS_STATUS         8'h10
`define RESET_CONTROL_ZERO 8'h00
`define RESET_CONTROL_ONE  8'h80
`define BIT_REF_UPPER      7
`define BIT_REF_LOWER      0
`define FLD_BUF_HI         2
`define FLD_BUF_LO         0
`define FLD_RSVD_HI        6
`define FLD_RSVD_LO        3
`define BIT_STATUS_BUSY    0
`define BIT_STATUS_RSVD    1
`define RESULT_BITS        13
`define LOWER_BITS         5
`define ADDR_LSB           2
`endif

// ==== core/adc_readout_pkg.sv ====
// types shared by the converter register block
package adc_readout_pkg;
   typedef enum logic [2:0] {
      BUF_SE_UNBUF   = 3'h0,
      BUF_SE_BUF     = 3'h1,
      BUF_DIFF_UNBUF = 3'h4,
      BUF_DIFF_BUF   = 3'h5
   } buf_mode_e;
   typedef enum logic [1:0] {
      REF_EXTERNAL = 2'h0,
      REF_INT_1V0  = 2'h1,
      REF_INT_2V0  = 2'h2,
      REF_RESERVED = 2'h3
   } ref_sel_e;
   typedef struct packed {
      logic        valid;
      logic [12:0] value;
   } result_s;
   typedef struct packed {
      logic       differential;
      logic       buffered;
      logic       reserved_code;
      ref_sel_e   reference;
   } analog_cfg_s;
endpackage : adc_readout_pkg

// ==== core/adc_cfg_decode.sv ====
// decodes buffer mode and reference level into analog steering controls
`timescale 1ns/1ps
`include "adc_readout_cfg.svh"
module adc_cfg_decode (
   input  wire logic [2:0]                 buf_sel_in,
   input  wire logic                       ref_upper_in,
   input  wire logic                       ref_lower_in,
   output adc_readout_pkg::analog_cfg_s    cfg_out
);
   import adc_readout_pkg::*;
   always_comb begin
      cfg_out = '0;
      case (buf_sel_in)
         BUF_SE_UNBUF:   cfg_out.buffered = 1'b0;
         BUF_SE_BUF:     cfg_out.buffered = 1'b1;
         BUF_DIFF_UNBUF: cfg_out.differential = 1'b1;
         BUF_DIFF_BUF: begin
            cfg_out.differential = 1'b1;
            cfg_out.buffered     = 1'b1;
         end
         // reserved codes fall back to single-ended unbuffered and are flagged
         default:        cfg_out.reserved_code = 1'b1;
      endcase
      cfg_out.reference = ref_sel_e'({ref_upper_in, ref_lower_in});
   end
endmodule : adc_cfg_decode

// ==== core/adc_result_readout_config.sv ====
// converter control registers and coherent result readout over classic wishbone
// Contract
// - buffer select 000 is single-ended unbuffered, 001 single-ended buffered, 010/011 reserved.
// - buffer select 100 is differential unbuffered, 101 differential buffered, 110/111 reserved.
// - the result is 13-bit two's complement, the upper byte register holding the top eight bits.
// - the upper byte register is read-only and writes leave the result untouched.
// - reading the upper byte latches the matching lower bits into the low-bits register.
// - reference select {upper,lower} is 00 external, 01 1.0 V, 10 2.0 V default, 11 reserved.
//
// Our own choices: the Wishbone register port and the address map.
`timescale 1ns/1ps
`include "adc_readout_cfg.svh"
module adc_result_readout_config (
   input  wire logic                        mclk_in,
   input  wire logic                        rstn_in,
   input  wire logic                        wb_cyc_in,
   input  wire logic                        wb_stb_in,
   input  wire logic                        wb_we_in,
   input  wire logic [7:0]                  wb_adr_in,
   input  wire logic [3:0]                  wb_sel_in,
   input  wire logic [31:0]                 wb_dat_in,
   output logic      [31:0]                 wb_dat_out,
   output logic                             wb_ack_out,
   input  wire adc_readout_pkg::result_s    result_in,
   input  wire logic                        conv_busy_in,
   output adc_readout_pkg::analog_cfg_s     analog_cfg_out
);
   import adc_readout_pkg::*;

   // control group: the two control bytes and the registered analog setting
   logic [7:0]              ctl0_q;
   logic [7:0]              ctl0_d;
   logic [7:0]              ctl1_q;
   logic [7:0]              ctl1_d;
   analog_cfg_s             cfg_q;
   analog_cfg_s             cfg_d;
   analog_cfg_s             cfg_dec;

   // result group: stored result, latched low bits and the busy mirror
   logic [`RESULT_BITS-1:0] result_q;
   logic [`RESULT_BITS-1:0] result_d;
   logic [`LOWER_BITS-1:0]  lower_q;
   logic [`LOWER_BITS-1:0]  lower_d;
   logic                    busy_q;
   logic                    busy_d;

   // bus group: the registered answer
   logic [31:0]             dat_q;
   logic [31:0]             dat_d;
   logic                    ack_q;
   logic                    ack_d;

   // transfer decode and read words, no state of their own
   logic                    req;
   logic                    rd_take;
   logic                    wr_take;
   logic [7:0]              wr_byte;
   logic                    hit_ctl0;
   logic                    hit_ctl1;
   logic                    hit_upper;
   logic                    hit_lower;
   logic                    hit_status;
   logic [2:0]              buf_sel;
   logic                    ref_upper;
   logic                    ref_lower;
   logic [31:0]             ctl0_word;
   logic [31:0]             ctl1_word;
   logic [31:0]             upper_word;
   logic [31:0]             lower_word;
   logic [31:0]             status_word;
   logic [31:0]             rd_word;

   // a held strobe is taken once: the !ack_q term blocks the answering cycle
   always_comb begin
      req        = wb_cyc_in && wb_stb_in && !ack_q;
      // reads ignore the byte lanes and always return the whole word
      rd_take    = req && !wb_we_in;
      // only lane 0 carries a register byte; a write without it is ignored
      wr_take    = req && wb_we_in && wb_sel_in[0];
      wr_byte    = wb_dat_in[7:0];
      // whole byte address compared, so misaligned offsets hit nothing
      hit_ctl0   = (wb_adr_in == `OFS_CONTROL_ZERO);
      hit_ctl1   = (wb_adr_in == `OFS_CONTROL_ONE);
      hit_upper  = (wb_adr_in == `OFS_RESULT_UPPER);
      hit_lower  = (wb_adr_in == `OFS_RESULT_LOWER);
      hit_status = (wb_adr_in == `OFS_STATUS);
   end

   // field views of the control bytes
   always_comb begin
      buf_sel   = ctl1_q[`FLD_BUF_HI:`FLD_BUF_LO];
      ref_upper = ctl1_q[`BIT_REF_UPPER];
      ref_lower = ctl0_q[`BIT_REF_LOWER];
   end

   adc_cfg_decode u_decode (
      .buf_sel_in   (buf_sel),
      .ref_upper_in (ref_upper),
      .ref_lower_in (ref_lower),
      .cfg_out      (cfg_dec)
   );

   // control registers
   always_comb begin
      ctl0_d = ctl0_q;
      ctl1_d = ctl1_q;
      if (wr_take && hit_ctl0) begin
         ctl0_d = wr_byte;
      end
      if (wr_take && hit_ctl1) begin
         // reserved field is stored as written; software keeps it zero
         ctl1_d = wr_byte;
      end
      // the analog side only sees a decode of whole registered bytes,
      // at the cost of one cycle between the write and the new setting
      cfg_d = cfg_dec;
   end

   // in reset the analog side gets the all-zero setting; the decode of the
   // reset bytes follows at the first edge after release
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ctl0_q <= `RESET_CONTROL_ZERO;
         ctl1_q <= `RESET_CONTROL_ONE;
         cfg_q  <= '0;
      end else begin
         ctl0_q <= ctl0_d;
         ctl1_q <= ctl1_d;
         cfg_q  <= cfg_d;
      end
   end

   // result capture and lower-bit latch
   always_comb begin
      // only the converter moves the result; bus writes have no path here
      result_d = result_q;
      lower_d  = lower_q;
      busy_d   = conv_busy_in;
      // valid may be a pulse or a level; every high cycle overwrites
      if (result_in.valid) begin
         result_d = result_in.value;
      end
      // upper byte and low bits come from the same stored result, so the pair
      // stays coherent even when a new result lands in the cycle of the read
      if (rd_take && hit_upper) begin
         lower_d = result_q[`LOWER_BITS-1:0];
      end
   end

   // result and latch clear together, so a read straight after reset pairs zeros
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         result_q <= '0;
         lower_q  <= '0;
         busy_q   <= 1'b0;
      end else begin
         result_q <= result_d;
         lower_q  <= lower_d;
         busy_q   <= busy_d;
      end
   end

   // each readable register as a zero-padded bus word
   always_comb begin
      ctl0_word   = 32'h0;
      ctl1_word   = 32'h0;
      upper_word  = 32'h0;
      lower_word  = 32'h0;
      status_word = 32'h0;
      ctl0_word[7:0]  = ctl0_q;
      ctl1_word[7:0]  = ctl1_q;
      upper_word[7:0] = result_q[`RESULT_BITS-1:`LOWER_BITS];
      // latched bits sit at the bottom of the low-bits word
      lower_word[`LOWER_BITS-1:0] = lower_q;
      // busy lets software hold off reading a result that is still moving
      status_word[`BIT_STATUS_BUSY] = busy_q;
      status_word[`BIT_STATUS_RSVD] = cfg_q.reserved_code;
   end

   // read multiplexer
   // the order of the tests is immaterial: the hits exclude each other
   always_comb begin
      rd_word = 32'h0;
      if (hit_ctl0) begin
         rd_word = ctl0_word;
      end else if (hit_ctl1) begin
         rd_word = ctl1_word;
      end else if (hit_upper) begin
         rd_word = upper_word;
      end else if (hit_lower) begin
         rd_word = lower_word;
      end else if (hit_status) begin
         rd_word = status_word;
      end
   end

   // bus answer: one wait state, ack one cycle, data zero outside the answer
   always_comb begin
      ack_d = req;
      dat_d = 32'h0;
      if (rd_take) begin
         dat_d = rd_word;
      end
   end

   // ack and data share one register stage, so they are never a cycle apart
   always_ff @(posedge mclk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         dat_q <= 32'h0;
         ack_q <= 1'b0;
      end else begin
         dat_q <= dat_d;
         ack_q <= ack_d;
      end
   end

   // every output comes straight from a register
   assign wb_dat_out     = dat_q;
   assign wb_ack_out     = ack_q;
   assign analog_cfg_out = cfg_q;
endmodule : adc_result_readout_config

// ==== test/adc_readout_assertions.sv ====
// port assertions for the converter register block
`timescale 1ns/1ps
module adc_readout_assertions (
   input wire logic                         mclk_in,
   input wire logic                         rstn_in,
   input wire logic                         wb_we_in,
   input wire logic [7:0]                   wb_adr_in,
   input wire logic [3:0]                   wb_sel_in,
   input wire logic [31:0]                  wb_dat_in,
   input wire logic [31:0]                  wb_dat_out,
   input wire logic                         wb_ack_out,
   input wire adc_readout_pkg::analog_cfg_s analog_cfg_out
);
   import adc_readout_pkg::*;
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!rstn_in);
   // a write to control one that the design accepted (lane 0 enabled)
   wire w1 = wb_ack_out && wb_we_in && wb_sel_in[0] && wb_adr_in == 8'h04;
   a_ack_pulse: assert property (wb_ack_out |=> !wb_ack_out) else $error("ack too long");
   a_buf_single: assert property (w1 && wb_dat_in[2:0] == 3'h1 |-> ##[1:2]
      analog_cfg_out[4:2] == 3'b010) else $error("single buffered wrong");
   a_buf_diff: assert property (w1 && wb_dat_in[2:0] == 3'h5 |-> ##[1:2]
      analog_cfg_out[4:2] == 3'b110) else $error("differential buffered wrong");
   a_buf_rsvd: assert property (w1 && wb_dat_in[1] |-> ##[1:2]
      analog_cfg_out[4:2] == 3'b001) else $error("reserved code wrong");
   a_ref_dflt: assert property ($rose(rstn_in) |-> ##[0:2]
      analog_cfg_out.reference == REF_INT_2V0) else $error("reference default wrong");
   a_ref_upper: assert property (w1 && wb_dat_in[7] |-> ##[1:2]
      analog_cfg_out.reference[1]) else $error("reference upper bit wrong");
   a_unmap_zero: assert property (wb_ack_out && !wb_we_in && wb_adr_in > 8'h10 |->
      wb_dat_out == 32'h0) else $error("unmapped read not zero");
endmodule : adc_readout_assertions
bind adc_result_readout_config adc_readout_assertions adc_readout_assertions_inst (
   .mclk_in(mclk_in), .rstn_in(rstn_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
   .wb_sel_in(wb_sel_in),
   .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
   .analog_cfg_out(analog_cfg_out));

// ==== test/testbench.sv ====
// register-level bench for the converter register block
`timescale 1ns/1ps
`define CHK(n, e, s) begin n_compared++; if ((s) !== (e)) begin err_count++; \
   $display("MISMATCH %s exp %h got %h", n, e, s); end end
module testbench;
   import adc_readout_pkg::*;
   logic        mclk_in = 0, rstn_in = 0, cyc = 0, stb = 0, we = 0, busy = 0;
   logic [3:0]  sel = 4'h1, lane = 4'h1;
   logic [7:0]  adr = 0;
   logic [31:0] wdat = 0, rdat, q;
   logic        ack;
   result_s     res = '0;
   analog_cfg_s cfg;
   int          err_count = 0, n_compared = 0;
   adc_result_readout_config adc_result_readout_config_inst (.mclk_in(mclk_in),
      .rstn_in(rstn_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr),
      .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
      .result_in(res), .conv_busy_in(busy), .analog_cfg_out(cfg));
   initial forever #50 mclk_in = ~mclk_in;
   task automatic test_done;
      if (err_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   // one classic cycle; request held until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_in);
      {cyc, stb, we, adr, wdat, sel} <= {2'b11, w, a, d, lane};
      for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge mclk_in);
      if (i == 20) begin err_count++; test_done(); end
      q = rdat;
      {cyc, stb, we} <= 3'b0;
      @(posedge mclk_in);
   endtask : xfer
   initial begin
      logic [12:0] v0, v1;
      v0 = 13'h1abc;
      v1 = 13'h0123;
      repeat (10) @(posedge mclk_in);
      rstn_in <= 1'b1;
      xfer(0, 8'h04, 0);
      `CHK("ctl1_rst", 32'h80, q)
      `CHK("ref_rst", REF_INT_2V0, cfg.reference)
      for (int c = 0; c < 8; c++) begin
         xfer(1, 8'h00, {31'h0, c[0]});
         xfer(1, 8'h04, {24'h0, c[1], 4'h0, c[2:0]});
         xfer(0, 8'h04, 0);
         `CHK("ctl1", {24'h0, c[1], 4'h0, c[2:0]}, q)
         `CHK("buf", c[1] ? 3'b001 : {c[2], c[0], 1'b0}, cfg[4:2])
         `CHK("ref", c[1:0], cfg.reference)
      end
      // busy raised: status shows it, next to the reserved flag left by the last buffer code
      busy <= 1'b1;
      xfer(0, 8'h10, 0);
      `CHK("status_busy", 32'h3, q)
      busy <= 1'b0;
      // a write without lane 0 must leave control one as it was
      lane = 4'h0;
      xfer(1, 8'h04, 32'h01);
      lane = 4'h1;
      xfer(0, 8'h04, 0);
      `CHK("sel_off", 32'h87, q)
      xfer(0, 8'h10, 0);
      `CHK("status_idle", 32'h2, q)
      // results arrive as one-cycle pulses so a stray write could not be masked
      res <= {1'b1, v0};
      @(posedge mclk_in);
      res.valid <= 1'b0;
      xfer(0, 8'h08, 0);
      `CHK("upper", {24'h0, v0[12:5]}, q)
      // a newer result must not disturb the latched low bits
      res <= {1'b1, v1};
      @(posedge mclk_in);
      res.valid <= 1'b0;
      xfer(0, 8'h0c, 0);
      `CHK("low_hold", {27'h0, v0[4:0]}, q)
      xfer(1, 8'h08, 32'hff);
      xfer(0, 8'h08, 0);
      `CHK("upper_ro", {24'h0, v1[12:5]}, q)
      xfer(0, 8'h0c, 0);
      `CHK("low_new", {27'h0, v1[4:0]}, q)
      xfer(0, 8'h40, 0);
      `CHK("unmapped", 32'h0, q)
      test_done();
   end
endmodule : testbench
